// ### timer8_pkg.sv
// Purpose: constants for the 8-bit timer with prescaler and compare output
// Assumes: byte-wide register port, one clock
// Notes:   offsets are byte addresses on the register port
package timer8_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] timer_control_addr       = 8'h33;
  localparam logic [7:0] timer_count_value_addr   = 8'h32;
  localparam logic [7:0] timer_compare_value_addr = 8'h31;
  localparam logic [7:0] async_status_addr        = 8'h30;
  localparam logic [7:0] flag_register_addr       = 8'h34;
  localparam logic [7:0] special_function_addr    = 8'h35;
  // ==========================================================
  // control, status, special function and flag field positions
  localparam int force_bit     = 7;
  localparam int mode_hi_bit   = 3;
  localparam int mode_lo_bit   = 6;
  localparam int com_hi_bit    = 5;
  localparam int com_lo_bit    = 4;
  localparam int async_sel_bit = 3;
  localparam int sync_mode_bit = 7;
  localparam int psr_bit       = 1;
  localparam int cmp_flag_bit  = 1;
  localparam int ovf_flag_bit  = 0;
  // index of each asynchronously updated register
  localparam int idx_ctrl = 0;
  localparam int idx_cmp  = 1;
  localparam int idx_cnt  = 2;
  // ==========================================================
  // values
  localparam logic [7:0] reset_byte  = 8'h00;
  localparam logic [7:0] count_max   = 8'hff;
  localparam logic [7:0] count_bot   = 8'h00;
  localparam logic [1:0] land_stage  = 2'h1;
  localparam logic [9:0] pre_zero    = 10'h000;
  localparam logic [9:0] pre_one     = 10'h001;
  localparam logic [9:0] mask_div8   = 10'h007;
  localparam logic [9:0] mask_div32  = 10'h01f;
  localparam logic [9:0] mask_div64  = 10'h03f;
  localparam logic [9:0] mask_div128 = 10'h07f;
  localparam logic [9:0] mask_div256 = 10'h0ff;
  localparam logic [9:0] mask_div1k  = 10'h3ff;
  // ==========================================================
  // waveform modes, compare output actions and clock selects
  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_phase  = 2'b01,
    mode_clear_on_match = 2'b10,
    mode_fast   = 2'b11
  } wave_mode_e;
  typedef enum logic [1:0] {
    com_off    = 2'b00,
    com_toggle = 2'b01,
    com_clear  = 2'b10,
    com_set    = 2'b11
  } com_e;
  localparam logic [2:0] cs_stop = 3'h0;
  localparam logic [2:0] cs_div1 = 3'h1;
  localparam logic [2:0] cs_div8 = 3'h2;
endpackage

// ### timer8.sv
// Purpose: 8-bit timer/counter, prescaler, four waveform modes, one compare output
// Assumes: crystal_input_pin is a slow pin level, sampled on clk
// Notes:   asynchronous mode ticks on synchronised crystal edges, not on its own clock
`timescale 1ns/100ps
// How it works
// - reset selects system clock as source
// - async select uses crystal, frees crystal pins
// - clock select: stop, undivided, 8..1024
// - prescaler reset bit clears divider chain
// - force only in non-PWM modes
// - force applies compare action to pin
// - force sets no flag, never clears counter
// - force bit always reads zero
// - two mode bits pick four count modes
// - compare update time and overflow point per mode
// - nonzero compare mode overrides the port pin
// - non-PWM: toggle, clear or set on match
// - fast PWM: act on match, inverse at bottom
// - fast PWM: compare at top ignores match
// - phase PWM: up match one way, down other
// - phase PWM: compare at top acts at top
// - counter write blocks next tick's match
// - counter register reads counter directly, writes it directly unless async
// - every tick not blocked by a counter write compares value against counter
// - match flag: set, vector or one clears
// - overflow flag set on overflow, same clears
// - async writes set busy until landed
module timer8 (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // interrupt vector taken, one-cycle pulses
  input  wire logic       compare_vector_ack,
  input  wire logic       overflow_vector_ack,
  // pins and requests
  input  wire logic       crystal_input_pin,
  output logic            crystal_pins_released,
  output logic            compare_output_pin,
  output logic            compare_pin_override,
  output logic            compare_irq,
  output logic            overflow_irq
);
  // ==========================================================
  // crystal edge detect
  logic       xtal_s1;
  logic       xtal_s2;
  logic       xtal_s3;
  logic       xtal_rise;
  logic       async_sel;
  logic       src_tick;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
    end
    else
    begin
      xtal_s1 <= crystal_input_pin;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
    end
  end
  assign xtal_rise = xtal_s2 & ~xtal_s3;
  assign src_tick  = async_sel ? xtal_rise : 1'b1;
  // ==========================================================
  // temporary storage and busy flags
  logic [7:0] temp [3];
  logic [2:0] busy;
  logic [1:0] stage [3];
  logic [2:0] wr_hit;
  logic [2:0] land;
  logic [7:0] land_val [3];
  assign wr_hit[timer8_pkg::idx_ctrl] = wr && addr == timer8_pkg::timer_control_addr;
  assign wr_hit[timer8_pkg::idx_cmp]  = wr && addr == timer8_pkg::timer_compare_value_addr;
  assign wr_hit[timer8_pkg::idx_cnt]  = wr && addr == timer8_pkg::timer_count_value_addr;
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_upd
      assign land[g] = async_sel ? (busy[g] && xtal_rise && stage[g] == timer8_pkg::land_stage)
                                 : wr_hit[g];
      assign land_val[g] = async_sel ? temp[g] : wdata;
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          temp[g]  <= timer8_pkg::reset_byte;
          busy[g]  <= 1'b0;
          stage[g] <= 2'h0;
        end
        else if (wr_hit[g])
        begin
          temp[g]  <= wdata;
          busy[g]  <= async_sel;
          stage[g] <= 2'h0;
        end
        else if (land[g])
          busy[g]  <= 1'b0;
        else if (busy[g] && xtal_rise)
          stage[g] <= stage[g] + 2'h1;
      end
    end
  endgenerate
  // ==========================================================
  // control, status and special function registers
  logic [7:0] control;
  logic       sync_hold;
  logic       psr;
  logic       force_event;
  logic [1:0] mode;
  logic [1:0] com;
  logic [2:0] cs;
  assign mode = {control[timer8_pkg::mode_hi_bit], control[timer8_pkg::mode_lo_bit]};
  assign com  = control[timer8_pkg::com_hi_bit:timer8_pkg::com_lo_bit];
  assign cs   = control[2:0];
  // strobe is taken from the landing value and never stored
  assign force_event = land[timer8_pkg::idx_ctrl] && land_val[timer8_pkg::idx_ctrl][timer8_pkg::force_bit]
                       && !land_val[timer8_pkg::idx_ctrl][timer8_pkg::mode_lo_bit];
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      control <= timer8_pkg::reset_byte;
    else if (land[timer8_pkg::idx_ctrl])
      control <= land_val[timer8_pkg::idx_ctrl] & ~(8'h01 << timer8_pkg::force_bit);
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      async_sel <= 1'b0;
    else if (wr && addr == timer8_pkg::async_status_addr)
      async_sel <= wdata[timer8_pkg::async_sel_bit];
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_hold <= 1'b0;
      psr       <= 1'b0;
    end
    else if (wr && addr == timer8_pkg::special_function_addr)
    begin
      sync_hold <= wdata[timer8_pkg::sync_mode_bit];
      psr       <= wdata[timer8_pkg::psr_bit];
    end
    else if (!sync_hold && (!async_sel || xtal_rise))
      psr       <= 1'b0;
  end
  // ==========================================================
  // prescaler and tick select
  logic [9:0] pre;
  logic       tick;
  logic [9:0] pre_mask;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pre <= timer8_pkg::pre_zero;
    else if (psr)
      pre <= timer8_pkg::pre_zero;
    else if (src_tick)
      pre <= pre + timer8_pkg::pre_one;
  end
  always_comb
  begin
    case (cs)
      3'h2:    pre_mask = timer8_pkg::mask_div8;
      3'h3:    pre_mask = timer8_pkg::mask_div32;
      3'h4:    pre_mask = timer8_pkg::mask_div64;
      3'h5:    pre_mask = timer8_pkg::mask_div128;
      3'h6:    pre_mask = timer8_pkg::mask_div256;
      3'h7:    pre_mask = timer8_pkg::mask_div1k;
      default: pre_mask = timer8_pkg::pre_zero;
    endcase
  end
  assign tick = src_tick && !psr && cs != timer8_pkg::cs_stop
                && (pre & pre_mask) == pre_mask;
  // ==========================================================
  // counter, compare and match
  logic [7:0] count;
  logic [7:0] cmp_buf;
  logic [7:0] cmp_act;
  logic       down;
  logic       block_match;
  logic       match_event;
  logic       at_max;
  logic       at_bot;
  logic       ovf_event;
  logic       top_edge;
  assign at_max      = count == timer8_pkg::count_max;
  assign at_bot      = count == timer8_pkg::count_bot;
  assign match_event = tick && !block_match && count == cmp_act;
  assign top_edge    = tick && at_max;
  assign ovf_event   = (mode == timer8_pkg::mode_phase) ? (tick && down && at_bot)
                                                        : top_edge;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      block_match <= 1'b0;
    else if (land[timer8_pkg::idx_cnt])
      block_match <= 1'b1;
    else if (tick)
      block_match <= 1'b0;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= timer8_pkg::count_bot;
      down  <= 1'b0;
    end
    else if (land[timer8_pkg::idx_cnt])
      count <= land_val[timer8_pkg::idx_cnt];
    else if (tick)
    begin
      case (mode)
        timer8_pkg::mode_phase:
        begin
          if (!down && at_max)
          begin
            down  <= 1'b1;
            count <= count - 8'h01;
          end
          else if (down && at_bot)
          begin
            down  <= 1'b0;
            count <= count + 8'h01;
          end
          else
            count <= down ? count - 8'h01 : count + 8'h01;
        end
        timer8_pkg::mode_clear_on_match:
          count <= (count == cmp_act) ? timer8_pkg::count_bot : count + 8'h01;
        default:
          count <= count + 8'h01;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cmp_buf <= timer8_pkg::reset_byte;
    else if (land[timer8_pkg::idx_cmp])
      cmp_buf <= land_val[timer8_pkg::idx_cmp];
  end
  // double buffer only in the PWM modes, so a period is never cut short
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cmp_act <= timer8_pkg::reset_byte;
    else if (mode == timer8_pkg::mode_normal || mode == timer8_pkg::mode_clear_on_match
             || top_edge)
      cmp_act <= cmp_buf;
  end
  // ==========================================================
  // waveform generator
  logic wave;
  logic top_special;
  assign top_special = cmp_act == timer8_pkg::count_max && com[1];
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wave <= 1'b0;
    else
    begin
      case (mode)
        timer8_pkg::mode_fast:
        begin
          if (top_edge && com[1])
            wave <= (com == timer8_pkg::com_clear);
          else if (match_event && com[1])
            wave <= (com == timer8_pkg::com_set);
        end
        timer8_pkg::mode_phase:
        begin
          if (top_special && top_edge)
            wave <= (com == timer8_pkg::com_clear);
          else if (match_event && com[1] && !top_special)
            wave <= down ? (com == timer8_pkg::com_clear) : (com == timer8_pkg::com_set);
        end
        default:
        begin
          if (match_event || force_event)
          begin
            case (force_event ? land_val[timer8_pkg::idx_ctrl][timer8_pkg::com_hi_bit:
                                timer8_pkg::com_lo_bit] : com)
              timer8_pkg::com_toggle: wave <= ~wave;
              timer8_pkg::com_clear:  wave <= 1'b0;
              timer8_pkg::com_set:    wave <= 1'b1;
              default:                wave <= wave;
            endcase
          end
        end
      endcase
    end
  end
  // ==========================================================
  // flags and pin outputs
  logic cmp_flag;
  logic ovf_flag;
  logic flag_wr;
  assign flag_wr = wr && addr == timer8_pkg::flag_register_addr;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmp_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end
    else
    begin
      // a new event wins over a clear in the same cycle
      if (match_event)
        cmp_flag <= 1'b1;
      else if (compare_vector_ack || (flag_wr && wdata[timer8_pkg::cmp_flag_bit]))
        cmp_flag <= 1'b0;
      if (ovf_event)
        ovf_flag <= 1'b1;
      else if (overflow_vector_ack || (flag_wr && wdata[timer8_pkg::ovf_flag_bit]))
        ovf_flag <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      compare_output_pin    <= 1'b0;
      compare_pin_override  <= 1'b0;
      crystal_pins_released <= 1'b0;
      compare_irq           <= 1'b0;
      overflow_irq          <= 1'b0;
    end
    else
    begin
      compare_output_pin    <= wave;
      compare_pin_override  <= com != timer8_pkg::com_off;
      crystal_pins_released <= async_sel;
      compare_irq           <= cmp_flag;
      overflow_irq          <= ovf_flag;
    end
  end
  // ==========================================================
  // read port
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata <= timer8_pkg::reset_byte;
    else if (rd)
    begin
      case (addr)
        timer8_pkg::timer_control_addr:
          rdata <= temp[timer8_pkg::idx_ctrl] & ~(8'h01 << timer8_pkg::force_bit);
        timer8_pkg::timer_count_value_addr:   rdata <= count;
        timer8_pkg::timer_compare_value_addr: rdata <= temp[timer8_pkg::idx_cmp];
        timer8_pkg::async_status_addr: rdata <= {4'h0, async_sel, busy[timer8_pkg::idx_cnt],
                    busy[timer8_pkg::idx_cmp], busy[timer8_pkg::idx_ctrl]};
        timer8_pkg::flag_register_addr:       rdata <= {6'h00, cmp_flag, ovf_flag};
        timer8_pkg::special_function_addr:    rdata <= {sync_hold, 5'h00, psr, 1'b0};
        default:                              rdata <= timer8_pkg::reset_byte;
      endcase
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence div8_quiet;
    (cs == timer8_pkg::cs_div8 && !psr && !async_sel && !land[timer8_pkg::idx_ctrl]) [*7];
  endsequence
  force_reads_zero_a: assert property (rd && addr == timer8_pkg::timer_control_addr
    |=> !rdata[timer8_pkg::force_bit]) else $error("force bit read as one");
  match_sets_flag_a: assert property (match_event |=> cmp_flag ##1 compare_irq)
    else $error("match did not raise flag");
  force_no_flag_a: assert property (force_event && !match_event && !cmp_flag
    |=> !cmp_flag) else $error("forced compare set flag");
  stopped_count_a: assert property (cs == timer8_pkg::cs_stop && !land[timer8_pkg::idx_cnt]
    |=> $stable(count)) else $error("stopped timer moved");
  match_clear_a: assert property (mode == timer8_pkg::mode_clear_on_match && match_event
    && !land[timer8_pkg::idx_cnt] |=> count == timer8_pkg::count_bot)
    else $error("clear-on-match did not clear");
  div8_spacing_a: assert property ((tick && cs == timer8_pkg::cs_div8) ##1 div8_quiet
    |=> tick) else $error("divide by 8 spacing wrong");
  write_blocks_a: assert property (tick && block_match |=> !$rose(cmp_flag))
    else $error("match after counter write");
  async_busy_a: assert property (async_sel && wr_hit[timer8_pkg::idx_cnt]
    |=> busy[timer8_pkg::idx_cnt]) else $error("busy not set");
  fast_bottom_a: assert property (mode == timer8_pkg::mode_fast && top_edge
    && com == timer8_pkg::com_clear |=> wave ##1 compare_output_pin)
    else $error("fast pwm bottom not set");
  sys_clock_a: assert property (!async_sel && !psr |=> $changed(pre))
    else $error("system clock not source");
endmodule

// ### timer8_tb_top.sv
// Purpose: self-checking bench for the 8-bit timer with compare output
// Assumes: register map and control layout of timer8_pkg, fixed seed
// Notes:   duty counts are taken in steady state, one whole period long
`timescale 1ns/100ps
module timer8_tb_top;
  // ==========================================================
  // signals
  localparam logic [7:0] a_ctl = timer8_pkg::timer_control_addr;
  localparam logic [7:0] a_cnt = timer8_pkg::timer_count_value_addr;
  localparam logic [7:0] a_cmp = timer8_pkg::timer_compare_value_addr;
  localparam logic [7:0] a_st  = timer8_pkg::async_status_addr;
  localparam logic [7:0] a_fl  = timer8_pkg::flag_register_addr;
  localparam logic [7:0] a_sf  = timer8_pkg::special_function_addr;
  logic        clk;
  logic        rstn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        cva;
  logic        ova;
  logic        xtal;
  logic        rel;
  logic        pin;
  logic        ovr;
  logic        cirq;
  logic        oirq;
  int          miscompares;
  int          cmp_count;
  int          n;
  logic [7:0]  v;
  logic [7:0]  w;
  logic [7:0]  c;
  logic [1:0]  m;
  logic [1:0]  cm;
  logic [15:0] h;
  logic [1:0]  fcm [4];
  // ==========================================================
  // design
  timer8 i_timer8 (
    .clk                   (clk),
    .rstn                  (rstn),
    .addr                  (addr),
    .wdata                 (wdata),
    .wr                    (wr),
    .rd                    (rd),
    .rdata                 (rdata),
    .compare_vector_ack    (cva),
    .overflow_vector_ack   (ova),
    .crystal_input_pin     (xtal),
    .crystal_pins_released (rel),
    .compare_output_pin    (pin),
    .compare_pin_override  (ovr),
    .compare_irq           (cirq),
    .overflow_irq          (oirq)
  );
  // crystal runs free and out of phase with clk, well under a quarter of its rate
  initial clk = 1'b0;
  always #4 clk = ~clk;
  initial xtal = 1'b0;
  always #43 xtal = ~xtal;
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] ctl(input logic f, input logic [1:0] md,
                                     input logic [1:0] com, input logic [2:0] cs);
    return {f, md[0], com, md[1], cs};
  endfunction
  function automatic int div(input logic [2:0] cs);
    int t [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    return t[cs];
  endfunction
  // high cycles per period; compare at top keeps one level all period
  function automatic int hi_cycles(input logic [1:0] md, input logic [1:0] com, input int cv);
    int p;
    int hh;
    p  = (md == timer8_pkg::mode_fast) ? 256 : 510;
    hh = (cv == 255) ? p : ((md == timer8_pkg::mode_fast) ? cv + 1 : 2 * cv);
    return (com == timer8_pkg::com_set) ? p - hh : hh;
  endfunction
  // compare setup while stopped in normal mode, so the value lands at once
  task automatic setup(input logic [7:0] cr, input logic [7:0] cv, input logic [7:0] cn);
    wreg(a_ctl, 8'h00);
    wreg(a_cmp, cv);
    wreg(a_cnt, cn);
    wreg(a_fl, 8'h03);
    wreg(a_ctl, cr);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    rstn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cva = 1'b0;
    ova = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    fcm = '{timer8_pkg::com_clear, timer8_pkg::com_set, timer8_pkg::com_toggle,
            timer8_pkg::com_toggle};
    n = $urandom(72032);
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rreg(a_ctl, v);
    check("control reset", v, 16'h0000);
    rreg(a_st, v);
    check("status reset", v, 16'h0000);
    check("pins released", rel, 16'h0000);
    check("override", ovr, 16'h0000);
    wreg(8'h3f, 8'hff);
    rreg(8'h3f, v);
    check("unmapped", v, 16'h0000);
    // stopped counter keeps a written value
    w = 8'($urandom);
    setup(ctl(0, timer8_pkg::mode_normal, timer8_pkg::com_off, timer8_pkg::cs_stop), 8'h00, w);
    rreg(a_cnt, v);
    check("count write", v, w);
    cyc(20);
    rreg(a_cnt, v);
    check("stopped", v, w);
    for (int cs = 1; cs < 8; cs++)
    begin
      setup(ctl(0, timer8_pkg::mode_normal, timer8_pkg::com_off, 3'(cs)), 8'h00, 8'h00);
      rreg(a_cnt, v);
      cyc(4 * div(3'(cs)) - 2);
      rreg(a_cnt, w);
      check("tick rate", 16'(w - v), 16'h0004);
    end
    // prescaler held in reset stops ticks, release restarts the divide-by-8 phase
    setup(ctl(0, timer8_pkg::mode_normal, timer8_pkg::com_off, timer8_pkg::cs_div8), 8'h00, 8'h00);
    wreg(a_sf, 8'h82);
    rreg(a_cnt, v);
    cyc(40);
    rreg(a_cnt, w);
    check("prescaler held", w, v);
    wreg(a_sf, 8'h00);
    cyc(36);
    rreg(a_cnt, w);
    check("prescaler phase", 16'(w - v), 16'h0004);
    // match and overflow flags, cleared by vector and by writing one
    setup(ctl(0, timer8_pkg::mode_normal, timer8_pkg::com_off, timer8_pkg::cs_div1), 8'h30, 8'h00);
    cyc(64);
    rreg(a_fl, v);
    check("match flag", v, 16'h0002);
    check("compare irq", cirq, 16'h0001);
    @(posedge clk);
    cva <= 1'b1;
    @(posedge clk);
    cva <= 1'b0;
    cyc(2);
    check("vector clears", cirq, 16'h0000);
    cyc(250);
    check("overflow irq", oirq, 16'h0001);
    wreg(a_fl, 8'h01);
    rreg(a_fl, v);
    check("overflow cleared", v[0], 16'h0000);
    cyc(256);
    check("overflow again", oirq, 16'h0001);
    @(posedge clk);
    ova <= 1'b1;
    @(posedge clk);
    ova <= 1'b0;
    cyc(2);
    check("overflow vector", oirq, 16'h0000);
    // counter written onto the compare value gives no match
    setup(ctl(0, timer8_pkg::mode_normal, timer8_pkg::com_off, timer8_pkg::cs_div1), 8'h20, 8'h80);
    wreg(a_cnt, 8'h20);
    cyc(4);
    rreg(a_fl, v);
    check("match blocked", v[1], 16'h0000);
    // forced compare while stopped in clear-on-match mode, then ignored in phase PWM mode
    setup(ctl(0, timer8_pkg::mode_clear_on_match, timer8_pkg::com_off, timer8_pkg::cs_stop), 8'h00, 8'h55);
    for (int i = 0; i < 4; i++)
    begin
      wreg(a_ctl, ctl(1, timer8_pkg::mode_clear_on_match, fcm[i], timer8_pkg::cs_stop));
      cyc(3);
      check("forced pin", pin, 16'(i[0]));
      check("override", ovr, 16'h0001);
    end
    rreg(a_ctl, v);
    check("force reads", v[7], 16'h0000);
    rreg(a_fl, v);
    check("force flags", v, 16'h0000);
    rreg(a_cnt, v);
    check("force count", v, 16'h0055);
    wreg(a_ctl, ctl(1, timer8_pkg::mode_phase, timer8_pkg::com_clear, timer8_pkg::cs_stop));
    cyc(3);
    check("pwm force", pin, 16'h0001);
    // toggle on each match while running
    setup(ctl(0, timer8_pkg::mode_normal, timer8_pkg::com_toggle, timer8_pkg::cs_div1), 8'h10, 8'h00);
    cyc(300);
    v[0] = pin;
    cyc(256);
    check("toggle", pin, 16'(!v[0]));
    // clear-on-match keeps the counter at or below the compare value
    setup(ctl(0, timer8_pkg::mode_clear_on_match, timer8_pkg::com_off, timer8_pkg::cs_div1), 8'h10, 8'h00);
    repeat (6)
    begin
      cyc($urandom_range(1, 40));
      rreg(a_cnt, v);
      check("top", 16'(v > 8'h10), 16'h0000);
    end
    // pwm duty in both modes, both polarities, compare at top
    for (int i = 0; i < 8; i++)
    begin
      m  = i[2] ? timer8_pkg::mode_phase : timer8_pkg::mode_fast;
      cm = i[0] ? timer8_pkg::com_set : timer8_pkg::com_clear;
      c  = i[1] ? 8'hff : 8'($urandom_range(16, 224));
      setup(ctl(0, m, cm, timer8_pkg::cs_div1), c, 8'h00);
      n = (m == timer8_pkg::mode_fast) ? 256 : 510;
      cyc(2 * n);
      h = 16'h0000;
      repeat (n)
      begin
        cyc(1);
        h = h + 16'(pin);
      end
      check("duty", h, 16'(hi_cycles(m, cm, int'(c))));
    end
    // asynchronous source: pins freed, busy until the write lands
    wreg(a_ctl, 8'h00);
    wreg(a_st, 8'h08);
    cyc(3);
    check("pins released", rel, 16'h0001);
    w = 8'($urandom);
    wreg(a_cnt, w);
    rreg(a_st, v);
    check("busy set", v[2], 16'h0001);
    n = 0;
    while (v[2] === 1'b1 && n < 50)
    begin
      rreg(a_st, v);
      n++;
    end
    check("busy clears", v[2], 16'h0000);
    if (v[2] !== 1'b0)
      complete_run();
    rreg(a_cnt, v);
    check("async count", v, w);
    wreg(a_st, 8'h00);
    cyc(3);
    check("pins back", rel, 16'h0000);
    complete_run();
  end
endmodule
